// [four_mode_serial_port.sv]
// two identical four-mode serial ports behind the special function register port
// assumes timer overflow pulses arrive one cycle wide on sys_clk_i

// ----------------------------------------
// transmit fifo
// ----------------------------------------
module tx_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// one serial channel
// ----------------------------------------
module serial_channel
  import serial_port_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // register access
  input  wire logic       ctrl_wr_i,
  input  wire logic       buf_wr_i,
  input  wire logic [7:0] wdata_i,
  output logic [7:0]      ctrl_o,
  output logic [7:0]      rx_buf_o,
  output logic            tx_ready_o,
  // rate sources
  input  wire logic       timer1_ovf_i,
  input  wire logic       timer2_ovf_i,
  input  wire logic       tx_timer_select_i,
  input  wire logic       rx_timer_select_i,
  input  wire logic       mode2_rate_double_i,
  // line
  input  wire logic       rxd_i,
  output logic            rxd_o,
  output logic            rxd_oe_o,
  output logic            txd_o
);
  logic [1:0] mode_q;
  logic       filt_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
  logic [7:0] rx_buf_q;
  logic       rxd_meta_q, rxd_s_q;
  logic       ti_set, ri_set, rx_load, rx_ninth;
  logic [7:0] rx_data;
  // fifo
  logic       fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  // rate
  logic       t1_half_q;
  logic [1:0] m2_cnt_q;
  logic       t1_tick, m2_tick, tx_tick, rx_tick;
  // mode 0
  shift_state_type m0_state_q;
  logic [3:0] m0_div_q;
  logic [2:0] m0_bit_q;
  logic [7:0] m0_shift_q;
  logic       m0_end, m0_tx_go, m0_rx_go;
  // async transmit
  line_state_type tx_state_q;
  logic [10:0] tx_shift_q;
  logic [3:0]  tx_bits_q, tx_sub_q;
  logic        tx_go;
  // async receive
  line_state_type rx_state_q;
  logic [9:0] rx_shift_q;
  logic [3:0] rx_bit_q, rx_sub_q, rx_nbits;
  logic       rx_go, rx_mid, rx_fin, rx_pass;

  assign ctrl_o   = {mode_q, filt_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
  assign rx_buf_o = rx_buf_q;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // R18: mode select pair
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      mode_q <= CTRL_RESET[MODE_HI_BIT:MODE_LO_BIT];
      filt_q <= CTRL_RESET[FILT_BIT];
      ren_q  <= CTRL_RESET[REN_BIT];
      tb8_q  <= CTRL_RESET[TB8_BIT];
    end else if (ctrl_wr_i) begin
      mode_q <= wdata_i[MODE_HI_BIT:MODE_LO_BIT];
      filt_q <= wdata_i[FILT_BIT];
      ren_q  <= wdata_i[REN_BIT];
      tb8_q  <= wdata_i[TB8_BIT];
    end
  end

  // R25: flags sticky, hardware set wins
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ti_q  <= CTRL_RESET[TI_BIT];
      ri_q  <= CTRL_RESET[RI_BIT];
      rb8_q <= CTRL_RESET[RB8_BIT];
    end else begin
      ti_q  <= ti_set | (ctrl_wr_i ? wdata_i[TI_BIT] : ti_q);
      ri_q  <= ri_set | (ctrl_wr_i ? wdata_i[RI_BIT] : ri_q);
      if (rx_load && mode_q != MODE_SHIFT) rb8_q <= rx_ninth;
      else if (ctrl_wr_i)                  rb8_q <= wdata_i[RB8_BIT];
    end
  end

  // R3: holding register behind shifter
  // R26: overrun keeps unread byte
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) rx_buf_q <= '0;
    else if (rx_load) rx_buf_q <= rx_data;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rxd_meta_q <= 1'b1;
      rxd_s_q    <= 1'b1;
    end else begin
      rxd_meta_q <= rxd_i;
      rxd_s_q    <= rxd_meta_q;
    end
  end

  // ----------------------------------------
  // transmit queue
  // ----------------------------------------
  // R1: writes go to the transmit side
  // R15: each write queues a transmission unless the fifo is full
  tx_word_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .rstn_i     (rstn_i),
    .in_valid_i (buf_wr_i),
    .in_ready_o (tx_ready_o),
    .in_data_i  (wdata_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o (fifo_data)
  );
  assign fifo_pop = tx_go | m0_tx_go;

  // ----------------------------------------
  // bit rate ticks, sixteen per bit
  // ----------------------------------------
  // R23: timer 2 overflow is the 16x tick
  // R24: fixed divider osc/4 or osc/2 for 16x
  assign t1_tick = timer1_ovf_i & (mode2_rate_double_i | t1_half_q);
  assign m2_tick = (m2_cnt_q == (mode2_rate_double_i ? M2_DIV_FAST : M2_DIV_SLOW));
  // R9: R13: R14: R22: rate source per direction
  assign tx_tick = (mode_q == MODE_FIXED9) ? m2_tick
                 : (tx_timer_select_i ? timer2_ovf_i : t1_tick);
  assign rx_tick = (mode_q == MODE_FIXED9) ? m2_tick
                 : (rx_timer_select_i ? timer2_ovf_i : t1_tick);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      t1_half_q <= 1'b0;
      m2_cnt_q  <= '0;
    end else begin
      if (timer1_ovf_i) t1_half_q <= ~t1_half_q;
      m2_cnt_q <= m2_tick ? '0 : m2_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // mode 0 shift engine
  // ----------------------------------------
  // transmit has priority over a pending receive start
  assign m0_tx_go = (mode_q == MODE_SHIFT) && m0_state_q == M0_IDLE && fifo_valid;
  // R16: receive starts on clear flag and enable
  assign m0_rx_go = (mode_q == MODE_SHIFT) && m0_state_q == M0_IDLE && !fifo_valid
                    && ren_q && !ri_q;
  assign m0_end   = m0_state_q != M0_IDLE && m0_div_q == M0_LAST_DIV
                    && m0_bit_q == M0_LAST_BIT;

  // R5: R6: eight bits lsb first at osc/12
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      m0_state_q <= M0_IDLE;
      m0_div_q   <= '0;
      m0_bit_q   <= '0;
      m0_shift_q <= '0;
    end else begin
      case (m0_state_q)
        M0_IDLE: begin
          m0_div_q <= '0;
          m0_bit_q <= '0;
          if (m0_tx_go) begin
            m0_state_q <= M0_TX;
            m0_shift_q <= fifo_data;
          end else if (m0_rx_go) begin
            m0_state_q <= M0_RX;
          end
        end
        M0_TX, M0_RX: begin
          m0_div_q <= (m0_div_q == M0_LAST_DIV) ? '0 : m0_div_q + 1'b1;
          if (m0_state_q == M0_RX && m0_div_q == M0_RISE_DIV) begin
            m0_shift_q <= {rxd_s_q, m0_shift_q[7:1]};
          end
          if (m0_div_q == M0_LAST_DIV) begin
            m0_bit_q <= m0_bit_q + 1'b1;
            if (m0_state_q == M0_TX) m0_shift_q <= {1'b0, m0_shift_q[7:1]};
            if (m0_end) m0_state_q <= M0_IDLE;
          end
        end
        default: m0_state_q <= M0_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // async transmitter
  // ----------------------------------------
  // R2: independent of the receiver
  assign tx_go = (mode_q != MODE_SHIFT) && tx_state_q == LINE_IDLE && fifo_valid;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      tx_state_q <= LINE_IDLE;
      tx_shift_q <= '1;
      tx_bits_q  <= '0;
      tx_sub_q   <= '0;
    end else begin
      case (tx_state_q)
        LINE_IDLE: begin
          tx_sub_q <= '0;
          if (tx_go) begin
            tx_state_q <= LINE_RUN;
            // R7: R10: R11: start, data lsb first, ninth, stop
            tx_shift_q <= {1'b1, (mode_q[1] ? tb8_q : 1'b1), fifo_data, 1'b0};
            tx_bits_q  <= mode_q[1] ? BITS_MODE23 : BITS_MODE1;
          end
        end
        LINE_RUN: begin
          if (tx_tick) begin
            tx_sub_q <= tx_sub_q + 1'b1;
            if (tx_sub_q == OVS_LAST) begin
              tx_shift_q <= {1'b1, tx_shift_q[10:1]};
              tx_bits_q  <= tx_bits_q - 1'b1;
              if (tx_bits_q == 4'h1) tx_state_q <= LINE_IDLE;
            end
          end
        end
        default: tx_state_q <= LINE_IDLE;
      endcase
    end
  end

  // R25: flag at eighth bit end or stop start
  assign ti_set = (m0_end && m0_state_q == M0_TX)
                || (tx_state_q == LINE_RUN && tx_tick && tx_sub_q == OVS_LAST
                    && tx_bits_q == 4'h2);

  // ----------------------------------------
  // async receiver, centre sampled
  // ----------------------------------------
  assign rx_nbits = mode_q[1] ? BITS_MODE23 : BITS_MODE1;
  // R17: start bit seen while enabled
  assign rx_go  = (mode_q != MODE_SHIFT) && rx_state_q == LINE_IDLE && ren_q
                  && rx_tick && !rxd_s_q;
  assign rx_mid = rx_state_q == LINE_RUN && rx_tick && rx_sub_q == OVS_MID;
  assign rx_fin = rx_mid && rx_bit_q == rx_nbits - 4'h1;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rx_state_q <= LINE_IDLE;
      rx_shift_q <= '0;
      rx_bit_q   <= '0;
      rx_sub_q   <= '0;
    end else begin
      case (rx_state_q)
        LINE_IDLE: begin
          rx_sub_q <= '0;
          rx_bit_q <= '0;
          if (rx_go) rx_state_q <= LINE_RUN;
        end
        LINE_RUN: begin
          if (rx_tick) rx_sub_q <= rx_sub_q + 1'b1;
          if (rx_mid) begin
            rx_bit_q   <= rx_bit_q + 1'b1;
            rx_shift_q <= {rxd_s_q, rx_shift_q[9:1]};
            // false start or frame done at stop centre
            if ((rx_bit_q == '0 && rxd_s_q) || rx_fin) rx_state_q <= LINE_IDLE;
          end
        end
        default: rx_state_q <= LINE_IDLE;
      endcase
    end
  end

  // R8: R12: ninth is stop level in mode 1
  assign rx_ninth = mode_q[1] ? rx_shift_q[9] : rxd_s_q;
  assign rx_data  = (mode_q == MODE_SHIFT) ? m0_shift_q
                  : (mode_q[1] ? rx_shift_q[8:1] : rx_shift_q[9:2]);
  // R19: R21: filter on ninth or stop, not mode 0
  assign rx_pass  = !filt_q || rx_ninth;
  // R4: R26: completed byte dropped while flag set
  assign rx_load  = !ri_q && ((m0_end && m0_state_q == M0_RX) || (rx_fin && rx_pass));
  assign ri_set   = rx_load;

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign rxd_oe_o = (m0_state_q == M0_TX);
  assign rxd_o    = m0_shift_q[0];
  assign txd_o    = (mode_q == MODE_SHIFT)
                  ? (m0_state_q == M0_IDLE || m0_div_q >= M0_RISE_DIV)
                  : (tx_state_q == LINE_IDLE || tx_shift_q[0]);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_tx_start_low;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    tx_go |=> !txd_o [*2];
  endproperty
  a_tx_start_low: assert property (p_tx_start_low) else $error("start bit not low"); // R7

  property p_ti_cause;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(ti_q) && !$past(ctrl_wr_i) |-> $past(tx_state_q == LINE_RUN || m0_state_q == M0_TX);
  endproperty
  a_ti_cause: assert property (p_ti_cause) else $error("tx flag without transmit"); // R25

  property p_overrun_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    ri_q && !ctrl_wr_i |=> $stable(rx_buf_q);
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("unread byte overwritten"); // R26

  property p_m0_drive;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    rxd_oe_o |-> mode_q == MODE_SHIFT;
  endproperty
  a_m0_drive: assert property (p_m0_drive) else $error("data line driven outside mode 0"); // R5

  property p_m0_clock;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (m0_state_q != M0_IDLE && m0_div_q == '0) |-> !txd_o ##6 txd_o;
  endproperty
  a_m0_clock: assert property (p_m0_clock) else $error("shift clock shape wrong"); // R6

  property p_rx_enable;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    rx_state_q == LINE_IDLE ##1 rx_state_q == LINE_RUN |-> $past(ren_q);
  endproperty
  a_rx_enable: assert property (p_rx_enable) else $error("receive without enable"); // R17

  property p_addr_filter;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    rx_fin && mode_q[1] && filt_q && !rx_shift_q[9] && !ctrl_wr_i |=> ri_q == $past(ri_q);
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("data byte raised flag"); // R19

  c_async_rx:  cover property (@(posedge sys_clk_i) disable iff (!rstn_i) rx_fin && rx_load);
  c_m0_tx:     cover property (@(posedge sys_clk_i) disable iff (!rstn_i) m0_end && rxd_oe_o);
  c_overrun:   cover property (@(posedge sys_clk_i) disable iff (!rstn_i) rx_fin && ri_q);
  c_fifo_full: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) !tx_ready_o);
endmodule

// ----------------------------------------
// top: two ports on the register port
// ----------------------------------------
module four_mode_serial_port
  import serial_port_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rstn_i,
  // register port
  input  wire logic [7:0]           sfr_addr_i,
  input  wire logic [7:0]           sfr_wdata_i,
  input  wire logic                 sfr_wr_i,
  input  wire logic                 sfr_rd_i,
  output logic [7:0]                sfr_rdata_o,
  output logic [NUM_PORTS-1:0]      tx_ready_o,
  // rate sources
  input  wire logic                 timer1_ovf_i,
  input  wire logic                 timer2_ovf_i,
  input  wire logic [NUM_PORTS-1:0] tx_timer_select_i,
  input  wire logic [NUM_PORTS-1:0] rx_timer_select_i,
  input  wire logic                 mode2_rate_double_i,
  // lines
  input  wire logic [NUM_PORTS-1:0] rxd_i,
  output logic [NUM_PORTS-1:0]      rxd_o,
  output logic [NUM_PORTS-1:0]      rxd_oe_o,
  output logic [NUM_PORTS-1:0]      txd_o
);
  logic [7:0] ctrl   [NUM_PORTS];
  logic [7:0] rx_buf [NUM_PORTS];
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    serial_channel #(.FIFO_DEPTH(FIFO_DEPTH)) u_chan (
      .sys_clk_i          (sys_clk_i),
      .rstn_i             (rstn_i),
      .ctrl_wr_i          (sfr_wr_i && sfr_addr_i == CTRL_ADDR[p]),
      .buf_wr_i           (sfr_wr_i && sfr_addr_i == BUF_ADDR[p]),
      .wdata_i            (sfr_wdata_i),
      .ctrl_o             (ctrl[p]),
      .rx_buf_o           (rx_buf[p]),
      .tx_ready_o         (tx_ready_o[p]),
      .timer1_ovf_i       (timer1_ovf_i),
      .timer2_ovf_i       (timer2_ovf_i),
      .tx_timer_select_i  (tx_timer_select_i[p]),
      .rx_timer_select_i  (rx_timer_select_i[p]),
      .mode2_rate_double_i(mode2_rate_double_i),
      .rxd_i              (rxd_i[p]),
      .rxd_o              (rxd_o[p]),
      .rxd_oe_o           (rxd_oe_o[p]),
      .txd_o              (txd_o[p])
    );
  end

  // R1: buffer reads come from the receive side
  always_comb begin
    rdata_d = 8'h00;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (sfr_addr_i == CTRL_ADDR[p]) rdata_d = ctrl[p];
      if (sfr_addr_i == BUF_ADDR[p])  rdata_d = rx_buf[p];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) rdata_q <= 8'h00;
    else if (sfr_rd_i) rdata_q <= rdata_d;
  end
  assign sfr_rdata_o = rdata_q;

  property p_buf_read;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    sfr_rd_i && sfr_addr_i == BUF_ADDR[0] |=> sfr_rdata_o == $past(rx_buf[0]);
  endproperty
  a_buf_read: assert property (p_buf_read) else $error("buffer read not receive data"); // R1
endmodule

// [serial_port_pkg.sv]
// constants, register map and state types of the four-mode serial port
// assumes one oscillator clock for cpu side, port logic and timers
//
// Behaviour
// R1: buffer write feeds transmit, read gives receive
// R2: async transmit and receive run independently
// R3: receive register double buffered behind shifter
// R4: unread byte at completion loses one byte
// R5: mode 0 half duplex on receive line
// R6: mode 0 shift clock, 8 bits, osc/12
// R7: mode 1 frame: start, 8 data, stop
// R8: mode 1 stores stop level as ninth
// R9: modes 1 and 3 clocked by timers
// R10: mode 2 frame: start, 9 data, stop
// R11: modes 2/3 send tx_ninth_bit as ninth
// R12: modes 2/3 store ninth, ignore stop
// R13: mode 2 rate osc/32 or osc/64
// R14: mode 3 is mode 2 with timer rate
// R15: every buffer write starts a transmission; here a write while the fifo is full is dropped
// R16: mode 0 receive starts when flag clear
// R17: async receive starts on start bit, enabled
// R18: two select bits choose modes 0 to 3
// R19: modes 2/3 filter raises flag on ninth one
// R20: sender marks address bytes with ninth one
// R21: filter ignored mode 0, checks stop mode 1
// R22: timer selects pick timer 1 or 2
// R23: timer 2 rate divided by sixteen
// R24: rate double clear osc/64, set osc/32
// R25: tx flag set at eighth/stop bit, sticky
// R26: overrun keeps old byte, drops new
package serial_port_pkg;
  localparam int NUM_PORTS = 2;
  localparam logic [7:0] CTRL_ADDR [NUM_PORTS] = '{8'h98, 8'hD8};
  localparam logic [7:0] BUF_ADDR  [NUM_PORTS] = '{8'h99, 8'hD9};
  // port_control field positions
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int FILT_BIT    = 5;
  localparam int REN_BIT     = 4;
  localparam int TB8_BIT     = 3;
  localparam int RB8_BIT     = 2;
  localparam int TI_BIT      = 1;
  localparam int RI_BIT      = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  // timing
  localparam logic [3:0] M0_LAST_DIV  = 4'hB;  // osc/12 per bit
  localparam logic [3:0] M0_RISE_DIV  = 4'h6;
  localparam logic [2:0] M0_LAST_BIT  = 3'h7;
  localparam logic [1:0] M2_DIV_SLOW  = 2'h3;  // 16x tick at osc/4
  localparam logic [1:0] M2_DIV_FAST  = 2'h1;  // 16x tick at osc/2
  localparam logic [3:0] OVS_LAST     = 4'hF;  // sixteen ticks per bit
  localparam logic [3:0] OVS_MID      = 4'h7;
  localparam logic [3:0] BITS_MODE1   = 4'hA;
  localparam logic [3:0] BITS_MODE23  = 4'hB;
  typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} shift_state_type;
  typedef enum logic {LINE_IDLE, LINE_RUN} line_state_type;
endpackage

// [line_partner.sv]
// serial line partner: sends frames on the receive line, captures transmitted ones
// assumes the caller gives the clock cycles per bit of each frame
module line_partner (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle line rests high
  initial rxd_o = 1'b1;

  // start, lsb first, ninth marks address
  task automatic send(input logic [10:0] bits, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rxd_o <= bits[i];
      repeat (len - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask

  // sample each bit at its centre
  task automatic grab(output logic [10:0] bits, input int n, input int len);
    bits = '1;
    do @(posedge clk_i); while (txd_i !== 1'b0);
    repeat (len / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_i;
      repeat (len) @(posedge clk_i);
    end
  endtask
endmodule

// [four_mode_serial_port_test.sv]
// self-checking bench for the two-port serial block
// assumes timer 2 overflows every cycle, so sixteen cycles per bit in modes 1 and 3
`define check(got, want) begin checked++; if ((got) !== (want)) begin miscompares++; \
  $display("mismatch at %0t: got %h want %h", $time, got, want); end end

module four_mode_serial_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_port_pkg::*;

  logic       sys_clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lfsr_q = 8'h09, d, r, v;
  logic       wr = 1'b0, rd = 1'b0, t1 = 1'b0, dbl = 1'b0, line;
  logic [1:0] tsel = 2'h0, ready, rxd_oe, txd, rxdo;
  logic [10:0] got;
  int         miscompares = 0, checked = 0, cycles = 0, n;
  logic [7:0] rx_model [$];

  always #20 sys_clk_i = ~sys_clk_i;

  four_mode_serial_port four_mode_serial_port_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .tx_ready_o(ready),
    .timer1_ovf_i(t1), .timer2_ovf_i(1'b1), .tx_timer_select_i(tsel),
    .rx_timer_select_i(tsel), .mode2_rate_double_i(dbl), .rxd_i({2{line}}),
    .rxd_o(rxdo), .rxd_oe_o(rxd_oe), .txd_o(txd));

  line_partner line_partner_inst (.clk_i(sys_clk_i), .txd_i(txd[0]), .rxd_o(line));

  function automatic logic [7:0] next_rand();
    lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    return lfsr_q;
  endfunction

  // timer 1 is not selected, so its pulses must not disturb anything
  always @(posedge sys_clk_i) begin
    t1 <= lfsr_q[0];
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dat);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= dat;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] dat);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 dat = rdata;
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd_reg(CTRL_ADDR[0], v);
    `check(v, CTRL_RESET)
    `check({ready, txd, rxd_oe}, 6'h3C)
    rd_reg(8'h00, v);
    `check(v, 8'h00)
    tsel <= 2'h3;
    // ------------------------------------------------------------
    // mode 1 both directions at once
    // ------------------------------------------------------------
    wr_reg(CTRL_ADDR[0], 8'h50);
    d = next_rand();
    r = next_rand();
    rx_model.push_back(r);
    fork
      wr_reg(BUF_ADDR[0], d);
      line_partner_inst.grab(got, 10, 16);
      line_partner_inst.send({2'h3, r, 1'b0}, 10, 16);
    join
    `check(got[9:0], {1'b1, d, 1'b0})
    rd_reg(CTRL_ADDR[0], v);
    `check(v[2:0], 3'h7)
    // ------------------------------------------------------------
    // overrun: second byte dropped while flag set
    // ------------------------------------------------------------
    line_partner_inst.send({2'h3, next_rand(), 1'b0}, 10, 16);
    rd_reg(BUF_ADDR[0], v);
    r = rx_model.pop_front();
    `check(v, r)
    // ------------------------------------------------------------
    // mode 3 with address filter, ninth bit from control
    // ------------------------------------------------------------
    wr_reg(CTRL_ADDR[0], 8'hF8);
    d = next_rand();
    fork
      wr_reg(BUF_ADDR[0], d);
      line_partner_inst.grab(got, 11, 16);
      line_partner_inst.send({2'h2, next_rand(), 1'b0}, 11, 16);
    join
    `check(got, {2'h3, d, 1'b0})
    rd_reg(CTRL_ADDR[0], v);
    `check(v[0], 1'b0)
    r = next_rand();
    rx_model.push_back(r);
    line_partner_inst.send({2'h3, r, 1'b0}, 11, 16);
    rd_reg(CTRL_ADDR[0], v);
    `check(v[2:0], 3'h7)
    rd_reg(BUF_ADDR[0], v);
    r = rx_model.pop_front();
    `check(v, r)
    // ------------------------------------------------------------
    // mode 2 at both fixed rates, data byte with ninth clear
    // ------------------------------------------------------------
    for (n = 0; n < 2; n++) begin
      dbl <= n[0];
      wr_reg(CTRL_ADDR[0], 8'h98);
      d = next_rand();
      r = next_rand();
      rx_model.push_back(r);
      fork
        wr_reg(BUF_ADDR[0], d);
        line_partner_inst.grab(got, 11, 64 >> n);
        line_partner_inst.send({2'h2, r, 1'b0}, 11, 64 >> n);
      join
      `check(got, {2'h3, d, 1'b0})
      rd_reg(CTRL_ADDR[0], v);
      `check(v[2:0], 3'h3)
      rd_reg(BUF_ADDR[0], v);
      r = rx_model.pop_front();
      `check(v, r)
    end
    // ------------------------------------------------------------
    // mode 0: shift one byte out, then shift the idle line in
    // ------------------------------------------------------------
    wr_reg(CTRL_ADDR[0], 8'h00);
    d = next_rand();
    wr_reg(BUF_ADDR[0], d);
    for (n = 0; n < 8; n++) begin
      while (txd[0] !== 1'b0) @(posedge sys_clk_i);
      while (txd[0] !== 1'b1) @(posedge sys_clk_i);
      got[n] = rxdo[0];
      `check(rxd_oe[0], 1'b1)
    end
    `check(got[7:0], d)
    repeat (8) @(posedge sys_clk_i);
    rd_reg(CTRL_ADDR[0], v);
    `check(v[1:0], 2'h2)
    rx_model.push_back(8'hFF);
    wr_reg(CTRL_ADDR[0], 8'h10);
    repeat (110) @(posedge sys_clk_i);
    rd_reg(CTRL_ADDR[0], v);
    `check(v[1:0], 2'h1)
    rd_reg(BUF_ADDR[0], v);
    r = rx_model.pop_front();
    `check(v, r)
    // ------------------------------------------------------------
    // second port: fill the transmit fifo until it refuses, then wait until it accepts again
    // ------------------------------------------------------------
    wr_reg(CTRL_ADDR[1], 8'h40);
    @(posedge sys_clk_i);
    addr <= BUF_ADDR[1];
    wr <= 1'b1;
    for (n = 0; n < 33; n++) begin
      wdata <= next_rand();
      @(posedge sys_clk_i);
    end
    wr <= 1'b0;
    #1 `check(ready[1], 1'b0)
    n = 0;
    while (ready[1] !== 1'b1 && n < 8000) begin
      @(posedge sys_clk_i);
      n++;
    end
    `check(ready[1], 1'b1)
    results();
  end
endmodule
